/* logic/dual_dac_input_interface.sv */
`timescale 1ns/10ps
`include "dac_in_defs.svh"
module dual_dac_input_interface
  import dac_in_pkg::*;
#(
  parameter int FIFO_DEPTH = `DAC_FIFO_DEPTH
)
(
  input  wire logic                  CLK_I,
  input  wire logic                  ARST_N_I,
  input  wire logic                  MODE_DUAL_I,
  input  wire logic [`DAC_WIDTH-1:0] PORT_A_I,
  input  wire logic [`DAC_WIDTH-1:0] PORT_B_I,
  input  wire logic                  WRITE_STROBE_CHAN_A_I,
  input  wire logic                  WRITE_STROBE_CHAN_B_I,
  input  wire logic                  UPDATE_CLOCK_CHAN_A_I,
  input  wire logic                  UPDATE_CLOCK_CHAN_B_I,
  input  wire logic                  PAIR_ALIGN_RESET_I,
  input  wire logic                  GAIN_SHARE_SELECT_I,
  input  wire logic                  SINK_READY_I,
  output      logic [`DAC_WIDTH-1:0] CODE_A_O,
  output      logic [`DAC_WIDTH-1:0] CODE_B_O,
  output      logic [`DAC_WIDTH-1:0] COMP_A_O,
  output      logic [`DAC_WIDTH-1:0] COMP_B_O,
  output      logic                  UPDATE_A_O,
  output      logic                  UPDATE_B_O,
  output      logic                  HALVED_CORE_CLOCK_O,
  output      logic                  CHANNEL_STEER_O,
  output      logic                  BIAS_NODE_B_USED_O,
  output      logic                  FIFO_READY_O
);

  localparam int FW = 2 + 2 * `DAC_WIDTH;

  // Complement code for the second output of a channel
  function automatic code_t comp_of(input code_t c);
    comp_of = `DAC_CODE_MAX - c;
  endfunction : comp_of

  mode_e       mode;
  logic        dual;
  logic        wa_q;
  logic        wb_q;
  logic        ca_q;
  logic        cb_q;
  logic        ca_d;
  logic        cb_d;
  logic        halved;
  code_t       in_a;
  code_t       in_b;
  code_t       conv_a;
  code_t       conv_b;
  logic        push_q;
  logic        ua_q;
  logic        ub_q;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [FW-1:0] fifo_out;

  // Mode pin is static; its level picks the bus arrangement
  assign mode = MODE_DUAL_I ? MODE_DUAL : MODE_INTERLEAVED; // R03
  assign dual = (mode == MODE_DUAL);

  // Edge detection on synchronous strobe and clock pins
  wire wa_rise = WRITE_STROBE_CHAN_A_I & ~wa_q;
  wire wa_fall = ~WRITE_STROBE_CHAN_A_I & wa_q;
  wire wb_rise = WRITE_STROBE_CHAN_B_I & ~wb_q;
  wire ca_rise = UPDATE_CLOCK_CHAN_A_I & ~ca_q;
  wire cb_rise = UPDATE_CLOCK_CHAN_B_I & ~cb_q;

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      wa_q <= 1'b0;
      wb_q <= 1'b0;
      ca_q <= 1'b0;
      cb_q <= 1'b0;
    end
    else
    begin
      wa_q <= WRITE_STROBE_CHAN_A_I;
      wb_q <= WRITE_STROBE_CHAN_B_I;
      ca_q <= UPDATE_CLOCK_CHAN_A_I;
      cb_q <= UPDATE_CLOCK_CHAN_B_I;
    end
  end

  // Shared clock halved; pair reset pins its phase low
  wire next_halved = PAIR_ALIGN_RESET_I ? 1'b0 : // R14
                     (!dual && ca_rise) ? ~halved : halved; // R13

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      halved <= 1'b0;
    else
      halved <= next_halved;
  end

  // Steer follows the halved phase, so A is first after reset
  wire steer = ~halved; // R18

  // Capture enables; B bus is unused when interleaved
  wire cap_a = dual ? wa_rise : (wa_rise & steer); // R09
  wire cap_b = dual ? wb_rise : (wa_rise & ~steer); // R09 R04
  wire [`DAC_WIDTH-1:0] src_b = dual ? PORT_B_I : PORT_A_I; // R05

  // Unselected register feeds its own output back
  wire [`DAC_WIDTH-1:0] next_in_a = cap_a ? PORT_A_I : in_a; // R10
  wire [`DAC_WIDTH-1:0] next_in_b = cap_b ? src_b : in_b; // R10

  // Input registers; words pass as plain offset binary
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      in_a <= '0;
      in_b <= '0;
    end
    else
    begin
      in_a <= next_in_a; // R01 R06
      in_b <= next_in_b; // R06
    end
  end

  // Clock rise is delayed one cycle so a clock tied to the strobe
  // moves the word just captured, not the one before it
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      ca_d <= 1'b0;
      cb_d <= 1'b0;
    end
    else
    begin
      ca_d <= dual & ca_rise; // R07 R08
      cb_d <= dual & cb_rise; // R07 R08
    end
  end

  // Interleaved pair moves on the strobe fall that ends the B write
  wire xfer_pair = !dual && wa_fall && !halved && !PAIR_ALIGN_RESET_I; // R12 R11

  // A full FIFO stalls transfers; the stalled update is dropped
  wire stall  = push_q & ~fifo_in_ready;
  wire xfer_a = ((dual & ca_d) | xfer_pair) & ~stall; // R06
  wire xfer_b = ((dual & cb_d) | xfer_pair) & ~stall; // R06

  wire next_push = (xfer_a | xfer_b) ? 1'b1 :
                   (fifo_in_ready ? 1'b0 : push_q);

  // Converter registers and the pending push toward the FIFO
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      conv_a <= '0;
      conv_b <= '0;
      push_q <= 1'b0;
      ua_q   <= 1'b0;
      ub_q   <= 1'b0;
    end
    else
    begin
      if (xfer_a)
        conv_a <= in_a;
      if (xfer_b)
        conv_b <= in_b;
      push_q <= next_push;
      if (xfer_a | xfer_b)
      begin
        ua_q <= xfer_a;
        ub_q <= xfer_b;
      end
    end
  end

  // Buffer between the converter registers and the output stage
  sample_fifo
  #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .clk_i       (CLK_I),
    .arst_n_i    (ARST_N_I),
    .in_valid_i  (push_q),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({ua_q, ub_q, conv_a, conv_b}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (SINK_READY_I),
    .out_data_o  (fifo_out)
  );

  // Output stage; a sink that holds off backs the FIFO up
  wire   out_load = fifo_out_valid & SINK_READY_I;
  wire   word_ua  = fifo_out[`DAC_FLAG_A_BIT];
  wire   word_ub  = fifo_out[`DAC_FLAG_B_BIT];
  code_t word_a;
  code_t word_b;
  assign word_a = fifo_out[2*`DAC_WIDTH-1:`DAC_WIDTH];
  assign word_b = fifo_out[`DAC_WIDTH-1:0];

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      CODE_A_O   <= '0;
      CODE_B_O   <= '0;
      COMP_A_O   <= `DAC_CODE_MAX;
      COMP_B_O   <= `DAC_CODE_MAX;
      UPDATE_A_O <= 1'b0;
      UPDATE_B_O <= 1'b0;
    end
    else
    begin
      UPDATE_A_O <= out_load & word_ua; // R17
      UPDATE_B_O <= out_load & word_ub; // R17
      if (out_load & word_ua)
      begin
        CODE_A_O <= word_a; // R16
        COMP_A_O <= comp_of(word_a); // R16
      end
      if (out_load & word_ub)
      begin
        CODE_B_O <= word_b; // R16
        COMP_B_O <= comp_of(word_b); // R16
      end
    end
  end

  // Status levels; bias node B is used only in independent gain
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      BIAS_NODE_B_USED_O  <= 1'b0;
      HALVED_CORE_CLOCK_O <= 1'b0;
      CHANNEL_STEER_O     <= 1'b1;
    end
    else
    begin
      BIAS_NODE_B_USED_O  <= ~GAIN_SHARE_SELECT_I; // R15
      HALVED_CORE_CLOCK_O <= next_halved;
      CHANNEL_STEER_O     <= ~next_halved;
    end
  end

  assign FIFO_READY_O = fifo_in_ready;

  // Checks on the design's own behaviour
  default clocking cb_main @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  sequence s_dual_tied_write;
    dual && wa_rise && ca_rise && !push_q && !fifo_out_valid;
  endsequence

  sequence s_sink_open;
    SINK_READY_I [*4];
  endsequence

  // Sink must be open through the pop edge, three edges after capture
  a_dual_latency: assert property ( // R17
    s_dual_tied_write ##0 s_sink_open
      |=> (CODE_A_O == $past(PORT_A_I, `DAC_LATENCY)) && UPDATE_A_O)
    else $error("sample did not reach output after four cycles");

  a_pair_reset_low: assert property ( // R14
    PAIR_ALIGN_RESET_I |=> !halved && !HALVED_CORE_CLOCK_O)
    else $error("halved clock not held low by pair reset");

  a_steer_a_first: assert property ( // R18
    $past(PAIR_ALIGN_RESET_I) && !dual && wa_rise |-> cap_a && !cap_b)
    else $error("first write after pair reset not steered to A");

  a_halve_toggle: assert property ( // R13
    !dual && ca_rise && !PAIR_ALIGN_RESET_I |=> halved != $past(halved))
    else $error("halved clock did not toggle on shared clock");

  a_port_b_ignored: assert property ( // R05
    !dual && wa_rise && !steer |=> in_b == $past(PORT_A_I))
    else $error("interleaved B word not taken from port A");

  a_hold_unsel: assert property ( // R10
    !dual && wa_rise && steer |=> in_b == $past(in_b))
    else $error("unselected input register changed");

  a_dual_capture: assert property ( // R06
    dual && wb_rise |=> in_b == $past(PORT_B_I)
      && (in_a == $past(in_a) || $past(wa_rise)))
    else $error("dual bus B capture wrong");

  a_pair_update: assert property ( // R12
    xfer_pair && !stall |=> conv_a == $past(in_a) && conv_b == $past(in_b))
    else $error("interleaved pair not moved on strobe fall");

  a_comp_code: assert property ( // R16
    UPDATE_B_O |-> COMP_B_O == `DAC_CODE_MAX - CODE_B_O)
    else $error("complement code wrong");

  a_gain_share: assert property ( // R15
    $stable(GAIN_SHARE_SELECT_I)
      |=> BIAS_NODE_B_USED_O == !$past(GAIN_SHARE_SELECT_I))
    else $error("bias node selection wrong");

endmodule : dual_dac_input_interface

/* shared/dac_in_defs.svh */
// Function
// [R01] Ten-bit straight binary samples, bit nine MSB
// [R02] Host keeps update rate at most 200 MSPS
// [R03] Mode pin low interleaved, high dual bus
// [R04] Dual bus: own bus, strobe, clock each
// [R05] Interleaved mode ignores channel B bus
// [R06] Strobe rise captures, clock moves to converter
// [R07] Clock edge at or before strobe edge
// [R08] Tying clock and strobe meets the ordering
// [R09] Steer high loads A, low loads B
// [R10] Unselected input register recirculates its value
// [R11] Host sends interleaved words at double rate
// [R12] Capture on strobe rise, transfer on fall
// [R13] Shared clock halved drives converter registers
// [R14] Pair reset holds halved clock low
// [R15] Gain share pin selects common bias resistor
// [R16] True gets code, complement gets 1023 minus code
// [R17] Output appears four cycles after strobe edge
// [R18] Steer from halved phase, A first
`ifndef DAC_IN_DEFS_SVH
`define DAC_IN_DEFS_SVH

`define DAC_WIDTH      10
`define DAC_CODE_MAX   10'h3FF
`define DAC_FIFO_DEPTH 8
`define DAC_LATENCY    4
`define DAC_MAX_MSPS   200
`define DAC_CLK_NS     40
`define DAC_EDGE_SEP_NS 2
`define DAC_EDGE_SEP_CYC \
  (((`DAC_EDGE_SEP_NS + `DAC_CLK_NS - 1) / `DAC_CLK_NS) < 1 ? 1 : \
   ((`DAC_EDGE_SEP_NS + `DAC_CLK_NS - 1) / `DAC_CLK_NS))
`define DAC_FLAG_A_BIT 21
`define DAC_FLAG_B_BIT 20

`endif

/* shared/dac_in_pkg.sv */
`include "dac_in_defs.svh"
package dac_in_pkg;

  // Bus input modes, one-hot
  typedef enum logic [1:0]
  {
    MODE_INTERLEAVED = 2'b01,
    MODE_DUAL        = 2'b10
  } mode_e;

  typedef logic [`DAC_WIDTH-1:0] code_t;

endpackage : dac_in_pkg

/* logic/sample_fifo.sv */
`timescale 1ns/10ps
module sample_fifo
#(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
)
(
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             in_valid_i,
  output      logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output      logic             out_valid_o,
  input  wire logic             out_ready_i,
  output      logic [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire do_push = in_valid_i & in_ready_o;
  wire do_pop  = out_valid_o & out_ready_i;

  // Full and empty come straight from the occupancy count
  // Count is one bit wider than the pointers so DEPTH itself fits
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  // Storage is written only, never reset, to stay a plain RAM
  always_ff @(posedge clk_i)
  begin
    if (do_push)
      mem[wr_ptr] <= in_data_i;
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      if (do_pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      if (do_push && !do_pop)
        count <= count + (AW+1)'(1);
      else if (do_pop && !do_push)
        count <= count - (AW+1)'(1);
    end
  end

endmodule : sample_fifo

/* tb/sample_host.sv */
`timescale 1ns/10ps
module sample_host
(
  input  wire logic       clk_i,
  output      logic [9:0] port_a_o,
  output      logic [9:0] port_b_o,
  output      logic       strobe_a_o,
  output      logic       strobe_b_o
);
  // Idle bus levels before the first word
  initial
  begin
    port_a_o   = 10'h000;
    port_b_o   = 10'h000;
    strobe_a_o = 1'b0;
    strobe_b_o = 1'b0;
  end

  // One word per channel, offset binary; the bus shows the inverse
  // afterwards, so a late capture never sees a stale match
  task automatic send_dual(input logic [9:0] a, input logic [9:0] b,
                           input logic en_a, input logic en_b);
    @(negedge clk_i);
    port_a_o   = a;
    port_b_o   = b;
    strobe_a_o = en_a;
    strobe_b_o = en_b;
    @(negedge clk_i);
    strobe_a_o = 1'b0;
    strobe_b_o = 1'b0;
    port_a_o   = ~a;
    port_b_o   = ~b;
  endtask : send_dual

  // A word then B word on bus A at twice the core rate; bus B gets junk
  task automatic send_pair(input logic [9:0] a, input logic [9:0] b);
    send_dual(a, ~a, 1'b1, 1'b0);
    send_dual(b, ~b, 1'b1, 1'b0);
  endtask : send_pair
endmodule : sample_host

/* tb/tb_dual_dac_input_interface.sv */
`timescale 1ns/10ps
module tb_dual_dac_input_interface;
  logic       clk;
  logic       arst_n;
  logic       mode_dual;
  logic       pair_rst;
  logic       gain;
  logic       sink_rdy;
  logic [9:0] port_a;
  logic [9:0] port_b;
  logic       stb_a;
  logic       stb_b;
  logic [9:0] code_a;
  logic [9:0] code_b;
  logic [9:0] comp_a;
  logic [9:0] comp_b;
  logic       upd_a;
  logic       upd_b;
  logic       halved;
  logic       steer;
  logic       bias_b;
  logic       fifo_rdy;
  int         mismatches;
  int         checks_done;
  int         cycles;
  logic [9:0] vals [4] = '{10'h000, 10'h3FF, 10'h2A5, 10'h15A};

  sample_host host
  (
    .clk_i      (clk),
    .port_a_o   (port_a),
    .port_b_o   (port_b),
    .strobe_a_o (stb_a),
    .strobe_b_o (stb_b)
  );

  // Update clocks tied to strobes, the characterised connection
  dual_dac_input_interface #(.FIFO_DEPTH(2)) DUT
  (
    .CLK_I                 (clk),
    .ARST_N_I              (arst_n),
    .MODE_DUAL_I           (mode_dual),
    .PORT_A_I              (port_a),
    .PORT_B_I              (port_b),
    .WRITE_STROBE_CHAN_A_I (stb_a),
    .WRITE_STROBE_CHAN_B_I (stb_b),
    .UPDATE_CLOCK_CHAN_A_I (stb_a),
    .UPDATE_CLOCK_CHAN_B_I (stb_b),
    .PAIR_ALIGN_RESET_I    (pair_rst),
    .GAIN_SHARE_SELECT_I   (gain),
    .SINK_READY_I          (sink_rdy),
    .CODE_A_O              (code_a),
    .CODE_B_O              (code_b),
    .COMP_A_O              (comp_a),
    .COMP_B_O              (comp_b),
    .UPDATE_A_O            (upd_a),
    .UPDATE_B_O            (upd_b),
    .HALVED_CORE_CLOCK_O   (halved),
    .CHANNEL_STEER_O       (steer),
    .BIAS_NODE_B_USED_O    (bias_b),
    .FIFO_READY_O          (fifo_rdy)
  );

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches = mismatches + 1;
      report_and_stop();
    end
  end

  task automatic chk_code(input logic [9:0] got, input logic [9:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("BAD %0t code %h expected %h", $time, got, exp);
    end
  endtask : chk_code

  task automatic chk_bit(input logic got, input logic exp);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // Output is sampled at the falling edge after the third rising edge past the capturing edge
  task automatic wait_out();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : wait_out

  task automatic report_and_stop();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    mismatches  = 0;
    checks_done = 0;
    cycles      = 0;
    arst_n      = 1'b0;
    mode_dual   = 1'b1;
    pair_rst    = 1'b1;
    gain        = 1'b0;
    sink_rdy    = 1'b1;
    repeat (2) @(negedge clk);
    chk_code(code_a, 10'h000);
    chk_code(comp_a, 10'h3FF);
    chk_bit(fifo_rdy, 1'b1);
    arst_n = 1'b1;
    @(negedge clk);
    chk_bit(bias_b, 1'b1);
    gain = 1'b1;
    @(negedge clk);
    chk_bit(bias_b, 1'b0);
    // Both channels at once, boundary codes included
    foreach (vals[i])
    begin
      host.send_dual(vals[i], ~vals[i], 1'b1, 1'b1);
      wait_out();
      chk_code(code_a, vals[i]);
      chk_code(comp_a, 10'h3FF - vals[i]);
      chk_code(code_b, ~vals[i]);
      chk_code(comp_b, 10'h3FF - ~vals[i]);
      chk_bit(upd_a, 1'b1);
      chk_bit(upd_b, 1'b1);
    end
    // Channel A alone leaves B untouched
    host.send_dual(10'h155, 10'h0F0, 1'b1, 1'b0);
    wait_out();
    chk_code(code_a, 10'h155);
    chk_bit(upd_b, 1'b0);
    chk_code(code_b, ~vals[3]);
    // Stalled sink: fill the queue until it refuses, then drain
    sink_rdy = 1'b0;
    repeat (4) host.send_dual(10'h111, 10'h222, 1'b1, 1'b1);
    repeat (3) @(negedge clk);
    chk_bit(fifo_rdy, 1'b0);
    sink_rdy = 1'b1;
    repeat (10) @(negedge clk);
    chk_bit(fifo_rdy, 1'b1);
    // Interleaved: writes under pair reset must not run the halved clock
    mode_dual = 1'b0;
    host.send_dual(10'h001, 10'h002, 1'b1, 1'b0);
    host.send_dual(10'h003, 10'h004, 1'b1, 1'b0);
    chk_bit(halved, 1'b0);
    chk_bit(steer, 1'b1);
    // Let the last strobe fall be seen under reset, else it moves a pair
    @(negedge clk);
    pair_rst = 1'b0;
    @(negedge clk);
    foreach (vals[i])
    begin
      host.send_pair(vals[i], 10'h3FF - vals[i]);
      wait_out();
      chk_code(code_a, vals[i]);
      chk_code(code_b, 10'h3FF - vals[i]);
      chk_bit(upd_a, 1'b1);
      chk_bit(upd_b, 1'b1);
    end
    report_and_stop();
  end
endmodule : tb_dual_dac_input_interface
